/* lsp_core.sv */
/*
 * LIN status flags, identifier parity check and register map,
 * reached over a classic Wishbone slave with 8-bit data in the low lane.
 * Assumes a receiver front end supplies characters and header events
 * synchronous to CLK.
 */
// Our own choice: the Wishbone register port.
`timescale 1ns/100ps
`include "lsp_defs.svh"

// How it works
// - Status is read only and resets to c0.
// - Header error is set by a bad sync field, a header timeout or a header overrun.
// - A header error raises the receive interrupt when the receive enable is set.
// - Header error clears by status access then data read, only once sync state is cleared.
// - Outside a header the header error bit reports a receive overrun.
// - Noise flag works as normal in master role and stays zero in slave role.
// - In slave role a framing error needs a dominant stop bit and some recessive bit.
// - In slave role a break sets no framing error but sets header detect when select is 0.
// - Framing error clears by status access then data read.
// - With parity check on, a bad identifier parity sets the parity flag.
// - A parity error raises an interrupt when the parity enable is set.
// - Parity flag clears by status read then any data access.
// - Control one bit 2 enables identifier parity checking.
// - Control one resets to zero and bit 1 is reserved in LIN mode.
// - Offset 46 is the header length register in slave role and resets to zero.
module lsp_core
	import lsp_pkg::*;
(
	// Clock and reset
	input  wire logic           CLK,
	input  wire logic           RESET_N,
	// Wishbone slave
	input  wire logic           WB_CYC_I,
	input  wire logic           WB_STB_I,
	input  wire logic           WB_WE_I,
	input  wire logic [9:0]     WB_ADR_I,
	input  wire logic [3:0]     WB_SEL_I,
	input  wire logic [31:0]    WB_DAT_I,
	output logic      [31:0]    WB_DAT_O,
	output logic                WB_ACK_O,
	output logic                WB_ERR_O,
	// Receiver front end
	input  wire lsp_rxchar_type RX_CHAR,
	input  wire lsp_hdrev_type  HDR_EV,
	// Interrupt requests and mode outputs
	output logic                RX_IRQ,
	output logic                PARITY_IRQ,
	output logic                SLAVE_MODE
);

	lsp_state_type s_r;
	lsp_state_type s_nxt;

	logic       req;
	logic       wr;
	logic       rd;
	logic [7:0] idx;
	logic       hit;
	logic       line_on;
	logic       slave;
	logic       id_par_bad;
	logic       rx_over;
	logic       frame_bad;

	assign req     = WB_CYC_I && WB_STB_I && !s_r.ack;
	assign idx     = WB_ADR_I[9:2];
	assign hit     = (idx >= `LSP_IDX_STATUS) && (idx <= `LSP_IDX_FRAC);
	assign wr      = req && hit && WB_WE_I && WB_SEL_I[0];
	assign rd      = req && hit && !WB_WE_I;
	assign line_on = s_r.ctrl3[`LSP_C3_LINE];
	assign slave   = line_on && s_r.ctrl3[`LSP_C3_SLV];

	// Identifier parity per LIN: P0 = id0^1^2^4, P1 = ~(id1^3^4^5)
	assign id_par_bad = (RX_CHAR.data[6] != (RX_CHAR.data[0] ^ RX_CHAR.data[1]
		^ RX_CHAR.data[2] ^ RX_CHAR.data[4]))
		|| (RX_CHAR.data[7] != !(RX_CHAR.data[1] ^ RX_CHAR.data[3]
		^ RX_CHAR.data[4] ^ RX_CHAR.data[5]));

	assign rx_over   = RX_CHAR.valid && s_r.status[`LSP_ST_RX_FULL];
	// Dominant stop; in slave role also needs a recessive data bit
	assign frame_bad = !RX_CHAR.stop_bit && (slave ? (|RX_CHAR.data) : 1'b1);

	always_comb begin
		s_nxt      = s_r;
		s_nxt.ack  = req;
		if (req) begin
			s_nxt.rdata = 8'h00;
		end

		// Register reads
		if (rd) begin
			case (idx)
				`LSP_IDX_STATUS: s_nxt.rdata = s_r.status;
				`LSP_IDX_DATA:   s_nxt.rdata = s_r.data;
				`LSP_IDX_BAUD:   s_nxt.rdata = s_r.baud;
				`LSP_IDX_CTRL1:  s_nxt.rdata = s_r.ctrl1;
				`LSP_IDX_CTRL2:  s_nxt.rdata = s_r.ctrl2;
				`LSP_IDX_CTRL3:  s_nxt.rdata = s_r.ctrl3;
				`LSP_IDX_HDRLEN: s_nxt.rdata = s_r.hdrlen;
				`LSP_IDX_FRAC:   s_nxt.rdata = s_r.frac;
				default:         s_nxt.rdata = 8'h00;
			endcase
		end

		// Register writes; status is read only
		if (wr) begin
			case (idx)
				`LSP_IDX_DATA: begin
					s_nxt.status[`LSP_ST_TX_EMPTY] = 1'b0;
					s_nxt.status[`LSP_ST_TX_DONE]  = 1'b0;
				end
				`LSP_IDX_BAUD: s_nxt.baud = WB_DAT_I[7:0];
				`LSP_IDX_CTRL1: begin
					s_nxt.ctrl1 = WB_DAT_I[7:0];
					// Reserved bit 1 in LIN mode
					if (line_on) begin
						s_nxt.ctrl1[1] = 1'b0;
					end
				end
				`LSP_IDX_CTRL2:  s_nxt.ctrl2 = WB_DAT_I[7:0];
				`LSP_IDX_CTRL3: begin
					s_nxt.ctrl3 = WB_DAT_I[7:0];
					// Detect flag only cleared by software
					s_nxt.ctrl3[`LSP_C3_HDF] = s_r.ctrl3[`LSP_C3_HDF] & WB_DAT_I[`LSP_C3_HDF];
					// Sync state only cleared by software
					s_nxt.ctrl3[`LSP_C3_SYNC] = s_r.ctrl3[`LSP_C3_SYNC] & WB_DAT_I[`LSP_C3_SYNC];
				end
				`LSP_IDX_HDRLEN: s_nxt.hdrlen = WB_DAT_I[7:0];
				`LSP_IDX_FRAC: begin
					s_nxt.frac = slave ? (WB_DAT_I[7:0] & 8'h8f) : WB_DAT_I[7:0];
				end
				default: s_nxt.frac = s_nxt.frac;
			endcase
		end

		// Clear sequences on data access after armed status access
		if (req && hit && idx == `LSP_IDX_DATA) begin
			if (s_r.armed_rd) begin
				s_nxt.status[`LSP_ST_PARITY] = 1'b0;
			end
			if (s_r.armed_any && !WB_WE_I) begin
				if (!s_r.ctrl3[`LSP_C3_SYNC]) begin
					s_nxt.status[`LSP_ST_HDR_ERR] = 1'b0;
				end
				s_nxt.status[`LSP_ST_FRAME] = 1'b0;
				s_nxt.status[`LSP_ST_NOISE] = 1'b0;
			end
			if (!WB_WE_I) begin
				s_nxt.status[`LSP_ST_RX_FULL] = 1'b0;
			end
			s_nxt.armed_any = 1'b0;
			s_nxt.armed_rd  = 1'b0;
		end
		if (req && hit && idx == `LSP_IDX_STATUS) begin
			s_nxt.armed_any = 1'b1;
			s_nxt.armed_rd  = !WB_WE_I;
		end

		// Header phase tracking
		case (s_r.phase)
			LSP_IDLE_ST: begin
				if (HDR_EV.start && line_on) begin
					s_nxt.phase = LSP_HDR_ST;
				end
			end
			LSP_HDR_ST: begin
				if (HDR_EV.done) begin
					s_nxt.phase = LSP_RESP_ST;
				end else if (HDR_EV.timeout || HDR_EV.sync_bad) begin
					s_nxt.phase = LSP_IDLE_ST;
				end
			end
			LSP_RESP_ST: begin
				if (HDR_EV.start) begin
					s_nxt.phase = LSP_HDR_ST;
				end
			end
			default: s_nxt.phase = LSP_IDLE_ST;
		endcase

		// Hardware sets come last so they win over clears
		if (s_r.phase == LSP_HDR_ST) begin
			if (HDR_EV.sync_bad) begin
				s_nxt.status[`LSP_ST_HDR_ERR] = 1'b1;
				s_nxt.ctrl3[`LSP_C3_SYNC]     = 1'b1;
			end
			if (HDR_EV.timeout || rx_over) begin
				s_nxt.status[`LSP_ST_HDR_ERR] = 1'b1;
			end
		end else if (rx_over) begin
			s_nxt.status[`LSP_ST_HDR_ERR] = 1'b1;
		end

		if (RX_CHAR.valid) begin
			if (!rx_over) begin
				s_nxt.data = RX_CHAR.data;
			end
			s_nxt.status[`LSP_ST_RX_FULL] = 1'b1;
			if (RX_CHAR.noise && !slave) begin
				s_nxt.status[`LSP_ST_NOISE] = 1'b1;
			end
			if (slave && RX_CHAR.brk) begin
				if (!s_r.ctrl3[`LSP_C3_HDM]) begin
					s_nxt.ctrl3[`LSP_C3_HDF] = 1'b1;
				end
			end else if (frame_bad) begin
				s_nxt.status[`LSP_ST_FRAME] = 1'b1;
			end
			if (RX_CHAR.is_id && s_r.ctrl1[`LSP_C1_PCE] && id_par_bad) begin
				s_nxt.status[`LSP_ST_PARITY] = 1'b1;
			end
		end
		if (slave) begin
			s_nxt.status[`LSP_ST_NOISE] = 1'b0;
		end
	end

	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			s_r        <= '0;
			s_r.phase  <= LSP_IDLE_ST;
			s_r.status <= `LSP_RST_STATUS;
			s_r.ctrl1  <= `LSP_RST_CTRL1;
			s_r.ctrl2  <= `LSP_RST_ZERO;
			s_r.ctrl3  <= `LSP_RST_ZERO;
			s_r.hdrlen <= `LSP_RST_ZERO;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign WB_ACK_O   = s_r.ack;
	assign WB_ERR_O   = 1'b0;
	assign WB_DAT_O   = {24'h000000, s_r.rdata};
	assign RX_IRQ     = s_r.ctrl2[`LSP_C2_RIE] && (s_r.status[`LSP_ST_HDR_ERR]
		|| s_r.status[`LSP_ST_RX_FULL]);
	assign PARITY_IRQ = s_r.ctrl1[`LSP_C1_PIE] && s_r.status[`LSP_ST_PARITY];
	assign SLAVE_MODE = slave;

endmodule

/* lsp_defs.svh */
/*
 * Register offsets, field positions, reset values and timing counts
 * for the LIN status and identifier parity block.
 * Assumes a Wishbone byte-wide register window, one register per word.
 */
`ifndef LSP_DEFS_SVH
`define LSP_DEFS_SVH

// Printed register indices; byte address is four times the index
`define LSP_IDX_STATUS     8'h40
`define LSP_IDX_DATA       8'h41
`define LSP_IDX_BAUD       8'h42
`define LSP_IDX_CTRL1      8'h43
`define LSP_IDX_CTRL2      8'h44
`define LSP_IDX_CTRL3      8'h45
`define LSP_IDX_HDRLEN     8'h46
`define LSP_IDX_FRAC       8'h47

// Status fields
`define LSP_ST_TX_EMPTY    7
`define LSP_ST_TX_DONE     6
`define LSP_ST_RX_FULL     5
`define LSP_ST_IDLE        4
`define LSP_ST_HDR_ERR     3
`define LSP_ST_NOISE       2
`define LSP_ST_FRAME       1
`define LSP_ST_PARITY      0

// Control one fields
`define LSP_C1_PCE         2
`define LSP_C1_PIE         0
// Control two fields
`define LSP_C2_RIE         5
// Control three fields
`define LSP_C3_LINE        6
`define LSP_C3_SLV         5
`define LSP_C3_HDM         3
`define LSP_C3_HDF         1
`define LSP_C3_SYNC        0

// Reset values
`define LSP_RST_STATUS     8'hc0
`define LSP_RST_ZERO       8'h00
`define LSP_RST_CTRL1      8'h00

// Default header timeout in bit-sample cycles (device choice)
`define LSP_HDR_TIMEOUT    16'd1000

`endif

/* lsp_pkg.sv */
/*
 * Types for the LIN status and identifier parity block.
 * Assumes lsp_defs.svh is available for constants.
 */
package lsp_pkg;

	typedef enum logic [1:0] {
		LSP_IDLE_ST,
		LSP_HDR_ST,
		LSP_RESP_ST
	} lsp_phase_type;

	// Character delivered by the receiver front end
	typedef struct packed {
		logic       valid;
		logic [7:0] data;
		logic       stop_bit;
		logic       noise;
		logic       brk;
		logic       is_id;
	} lsp_rxchar_type;

	// Header events from the header detector
	typedef struct packed {
		logic start;
		logic done;
		logic sync_bad;
		logic timeout;
	} lsp_hdrev_type;

	typedef struct packed {
		lsp_phase_type phase;
		logic [7:0]    status;
		logic [7:0]    data;
		logic [7:0]    baud;
		logic [7:0]    ctrl1;
		logic [7:0]    ctrl2;
		logic [7:0]    ctrl3;
		logic [7:0]    hdrlen;
		logic [7:0]    frac;
		logic          armed_any;
		logic          armed_rd;
		logic          ack;
		logic [7:0]    rdata;
	} lsp_state_type;

endpackage

/* lsp_lin_node.sv */
/* Behavioural model of the far LIN nodes: characters and header events.
 * Assumes the bench calls its tasks from CLK-synchronous code. */
`timescale 1ns/100ps
module lsp_lin_node
	import lsp_pkg::*;
(
	// Clock
	input  wire logic     CLK,
	// Receiver side
	output lsp_rxchar_type RX_CHAR,
	output lsp_hdrev_type  HDR_EV
);
	initial begin
		RX_CHAR = '0;
		HDR_EV = '0;
	end
	// One character, data scrambled once the pulse is gone
	task automatic send(input logic [7:0] d, input logic stp, nz, brk, id);
		@(posedge CLK);
		RX_CHAR <= '{1'b1, d, stp, nz, brk, id};
		@(posedge CLK);
		RX_CHAR.valid <= 1'b0;
		RX_CHAR.data <= ~d;
		#1;
	endtask
	task automatic hdr(input lsp_hdrev_type e);
		@(posedge CLK);
		HDR_EV <= e;
		@(posedge CLK);
		HDR_EV <= '0;
		#1;
	endtask
endmodule

/* lsp_core_monitor.sv */
/* Checker for lsp_core, bound to every instance.
 * Assumes a single CLK domain with synchronous RESET_N. */
`timescale 1ns/100ps
module lsp_core_monitor
	import lsp_pkg::*;
(
	input wire logic           CLK, RESET_N, WB_CYC_I, WB_STB_I, WB_WE_I,
	input wire logic [9:0]     WB_ADR_I,
	input wire logic [3:0]     WB_SEL_I,
	input wire logic [31:0]    WB_DAT_I, WB_DAT_O,
	input wire logic           WB_ACK_O, WB_ERR_O, RX_IRQ, PARITY_IRQ, SLAVE_MODE,
	input wire lsp_rxchar_type RX_CHAR,
	input wire lsp_hdrev_type  HDR_EV
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RESET_N);
	AST_ACK_LAT: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
		else $error("ack late");
	AST_ACK_PULSE: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack held");
	AST_ACK_CAUSE: assert property (WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I))
		else $error("ack without request");
	AST_RD_HI: assert property (WB_ACK_O |-> WB_DAT_O[31:8] == 24'h0) else $error("upper data");
	AST_SLV_NOISE: assert property (WB_ACK_O && !WB_WE_I && WB_ADR_I == 10'h100 && SLAVE_MODE
		|-> !WB_DAT_O[2]) else $error("noise in slave role");
	AST_PIRQ_SET: assert property ($rose(PARITY_IRQ) |-> $past(RX_CHAR.valid
		|| WB_CYC_I && WB_STB_I && WB_WE_I)) else $error("parity irq cause");
	AST_PIRQ_CLR: assert property ($fell(PARITY_IRQ) |-> $past(WB_CYC_I && WB_STB_I))
		else $error("pirq drop");
	AST_RIRQ_SET: assert property ($rose(RX_IRQ) |-> $past(RX_CHAR.valid || HDR_EV.sync_bad
		|| HDR_EV.timeout || WB_CYC_I && WB_STB_I && WB_WE_I)) else $error("rx irq cause");
	AST_RIRQ_CLR: assert property ($fell(RX_IRQ) |-> $past(WB_CYC_I && WB_STB_I))
		else $error("rx irq drop");
	AST_SLV_WR: assert property ($changed(SLAVE_MODE) |-> $past(WB_CYC_I && WB_STB_I && WB_WE_I))
		else $error("role change");
endmodule
bind lsp_core lsp_core_monitor lsp_core_monitor_inst (.CLK(CLK), .RESET_N(RESET_N),
	.WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I),
	.WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
	.WB_ERR_O(WB_ERR_O), .RX_IRQ(RX_IRQ), .PARITY_IRQ(PARITY_IRQ), .SLAVE_MODE(SLAVE_MODE),
	.RX_CHAR(RX_CHAR), .HDR_EV(HDR_EV));

/* lsp_core_bench.sv */
/* Self-checking bench for lsp_core with the LIN node model.
 * Assumes registers at byte address four times the index. */
`timescale 1ns/100ps
module lsp_core_bench
	import lsp_pkg::*;
;
	logic           clk = 0, rst_n = 0, cyc = 0, we = 0, ack, err, rirq, pirq, slv;
	logic [9:0]     adr = '0;
	logic [31:0]    wdat = '0, rdat;
	logic [7:0]     v;
	lsp_rxchar_type rxc;
	lsp_hdrev_type  hev;
	int             miscompares = 0, n_compared = 0, cycles = 0;
	always #5 clk = ~clk;
	lsp_core lsp_core_inst (.CLK(clk), .RESET_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(cyc),
		.WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
		.WB_ACK_O(ack), .WB_ERR_O(err), .RX_CHAR(rxc), .HDR_EV(hev), .RX_IRQ(rirq),
		.PARITY_IRQ(pirq), .SLAVE_MODE(slv));
	lsp_lin_node lsp_lin_node_inst (.CLK(clk), .RX_CHAR(rxc), .HDR_EV(hev));
	task automatic tally_and_finish;
		$display("compared %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			tally_and_finish;
		end
	end
	// Classic single cycle, data taken and request released at the edge that samples ack
	task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d);
		@(posedge clk);
		cyc <= 1;
		we <= w;
		adr <= {idx, 2'b00};
		wdat <= {24'h0, d};
		do begin
			@(posedge clk);
		end while (ack !== 1'b1);
		v = rdat[7:0];
		cyc <= 0;
		we <= 0;
	endtask
	task automatic chk(input string nm, input logic [7:0] e, g);
		n_compared++;
		if (g !== e) begin
			miscompares++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic t_reset;
		wb(0, 8'h40, 0); chk("status", 8'hc0, v);
		wb(1, 8'h40, 0); wb(0, 8'h40, 0); chk("status ro", 8'hc0, v);
		wb(0, 8'h43, 0); chk("ctrl1", 8'h00, v);
		wb(0, 8'h46, 0); chk("hdrlen", 8'h00, v);
		wb(0, 8'h50, 0); chk("unmapped", 8'h00, v);
	endtask
	task automatic t_parity;
		wb(1, 8'h45, 8'h40); wb(1, 8'h43, 8'h07);
		wb(0, 8'h43, 0); chk("ctrl1", 8'h05, v);
		lsp_lin_node_inst.send(8'h80, 1, 1, 0, 1);
		wb(0, 8'h40, 0); chk("pe good", 0, v[0]);
		chk("noise master", 1, v[2]);
		wb(0, 8'h41, 0); lsp_lin_node_inst.send(8'h00, 1, 0, 0, 1);
		chk("pirq", 1, pirq);
		wb(0, 8'h40, 0); chk("pe bad", 1, v[0]);
		wb(0, 8'h41, 0); chk("pirq clr", 0, pirq);
		wb(1, 8'h43, 8'h01); lsp_lin_node_inst.send(8'h00, 1, 0, 0, 1);
		wb(0, 8'h40, 0); chk("pe off", 0, v[0]);
		lsp_lin_node_inst.send(8'h80, 1, 0, 0, 0);
		wb(0, 8'h40, 0); chk("overrun", 1, v[3]);
		wb(0, 8'h41, 0); wb(0, 8'h40, 0); chk("overrun clr", 0, v[3]);
	endtask
	task automatic t_frame;
		wb(1, 8'h45, 8'h60); chk("slave", 1, slv);
		lsp_lin_node_inst.send(8'h01, 0, 1, 0, 0);
		wb(0, 8'h40, 0); chk("fe", 1, v[1]);
		chk("noise slave", 0, v[2]);
		wb(0, 8'h41, 0); wb(0, 8'h40, 0); chk("fe clr", 0, v[1]);
		lsp_lin_node_inst.send(8'h00, 0, 0, 0, 0);
		wb(0, 8'h40, 0); chk("fe dominant", 0, v[1]);
		wb(0, 8'h41, 0); lsp_lin_node_inst.send(8'h00, 0, 0, 1, 0);
		wb(0, 8'h40, 0); chk("fe break", 0, v[1]);
		wb(0, 8'h45, 0); chk("detect", 1, v[1]);
		wb(0, 8'h41, 0);
	endtask
	task automatic t_hdr;
		wb(1, 8'h44, 8'h20); wb(1, 8'h45, 8'h40);
		lsp_lin_node_inst.hdr(4'b1000); lsp_lin_node_inst.hdr(4'b0010);
		chk("rirq", 1, rirq);
		wb(0, 8'h40, 0); chk("hdr err", 1, v[3]);
		wb(0, 8'h41, 0); wb(0, 8'h40, 0); chk("held", 1, v[3]);
		wb(1, 8'h45, 8'h40); wb(0, 8'h40, 0); wb(0, 8'h41, 0);
		wb(0, 8'h40, 0); chk("hdr clr", 0, v[3]);
		lsp_lin_node_inst.hdr(4'b1000); lsp_lin_node_inst.hdr(4'b0001);
		wb(0, 8'h40, 0); chk("timeout", 1, v[3]);
	endtask
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1;
		t_reset;
		t_parity;
		t_frame;
		t_hdr;
		tally_and_finish;
	end
endmodule
